/* File: rtl/ppom_consts.svh */
// Named constants for the port pin override mux.
`ifndef PPOM_CONSTS_SVH
`define PPOM_CONSTS_SVH

// ==========================================================================
// Port geometry
// ==========================================================================
`define PPOM_PINS        8
`define PPOM_ADDR_W      12

// ==========================================================================
// Register byte offsets, one aligned word each
// ==========================================================================
`define PPOM_OFF_DIR     12'h000
`define PPOM_OFF_OUT     12'h004
`define PPOM_OFF_IN      12'h008
`define PPOM_OFF_CTRL    12'h00C

// ==========================================================================
// Field positions and reset values
// ==========================================================================
`define PPOM_CTRL_PUD    0
`define PPOM_RST_PINS    8'h00
`define PPOM_RST_BIT     1'b0
`define PPOM_RST_WORD    32'h0000_0000

`endif

/* File: rtl/ppom_pkg.sv */
// Types shared by the port pin override mux.
package ppom_pkg;

   // =======================================================================
   // Pin vector and module state
   // =======================================================================
   typedef logic [7:0] ppom_pins_t;

   typedef struct packed {
      ppom_pins_t  dir;
      ppom_pins_t  out;
      logic        global_pullup_disable;
      ppom_pins_t  sync1;
      ppom_pins_t  sync2;
      ppom_pins_t  pad_out;
      ppom_pins_t  pad_oe;
      ppom_pins_t  pull_en;
      ppom_pins_t  inen;
      ppom_pins_t  raw;
      ppom_pins_t  ana;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } ppom_state_t;

endpackage

/* File: rtl/ppom_top.sv */
// One eight-pin I/O port with alternate-function override logic and an APB slave.
`timescale 1ns/1ps
`include "ppom_consts.svh"

module ppom_top (
   // Clock and reset.
   input  wire logic               CLK,
   input  wire logic               RESET,
   // APB slave.
   input  wire logic               PSEL,
   input  wire logic               PENABLE,
   input  wire logic               PWRITE,
   input  wire logic [11:0]        PADDR,
   input  wire logic [31:0]        PWDATA,
   output logic [31:0]             PRDATA,
   output logic                    PREADY,
   output logic                    PSLVERR,
   // Sleep controller.
   input  wire logic               SLEEP,
   // Override signals from the alternate-function modules.
   input  wire ppom_pkg::ppom_pins_t PULLUP_OVERRIDE_EN,
   input  wire ppom_pkg::ppom_pins_t PULLUP_OVERRIDE_VAL,
   input  wire ppom_pkg::ppom_pins_t DIR_OVERRIDE_EN,
   input  wire ppom_pkg::ppom_pins_t DIR_OVERRIDE_VAL,
   input  wire ppom_pkg::ppom_pins_t VALUE_OVERRIDE_EN,
   input  wire ppom_pkg::ppom_pins_t VALUE_OVERRIDE_VAL,
   input  wire ppom_pkg::ppom_pins_t TOGGLE_OVERRIDE_EN,
   input  wire ppom_pkg::ppom_pins_t INEN_OVERRIDE_EN,
   input  wire ppom_pkg::ppom_pins_t INEN_OVERRIDE_VAL,
   // Signals back to the alternate-function modules.
   output ppom_pkg::ppom_pins_t    RAW_PIN_INPUT,
   output ppom_pkg::ppom_pins_t    ANALOG_PAD_SIGNAL,
   // Pad side.
   input  wire ppom_pkg::ppom_pins_t PAD_IN,
   input  wire ppom_pkg::ppom_pins_t PAD_ANALOG,
   output ppom_pkg::ppom_pins_t    PAD_OUT,
   output ppom_pkg::ppom_pins_t    PAD_OE,
   output ppom_pkg::ppom_pins_t    PULLUP_EN,
   output ppom_pkg::ppom_pins_t    INPUT_EN
);
   import ppom_pkg::*;

   // ======================================================================
   // State
   // ======================================================================
   ppom_state_t state_q;
   ppom_state_t state_d;

   // Combinational pin controls, also used by the next-state logic.
   ppom_pins_t  pull_d;
   ppom_pins_t  oe_d;
   ppom_pins_t  drive_d;
   ppom_pins_t  inen_d;
   logic        access;
   logic        hit_any;

   // ======================================================================
   // Helpers
   // ======================================================================
   // Address decode is used by both the write and the read path.
   function automatic logic reg_hit(input logic [11:0] addr, input logic [11:0] off);
      reg_hit = (addr == off);
   endfunction

   // The access phase completes when the slave has raised pready.
   assign access  = PSEL & PENABLE & state_q.pready;
   assign hit_any = reg_hit(PADDR, `PPOM_OFF_DIR) | reg_hit(PADDR, `PPOM_OFF_OUT)
                  | reg_hit(PADDR, `PPOM_OFF_IN)  | reg_hit(PADDR, `PPOM_OFF_CTRL);

   // ======================================================================
   // Pin override logic
   // ======================================================================
   // Each control is a plain two-way choice between the port bit (sleep for the input
   // enable) and the override; the overrides are inputs so every function owns its own.
   always_comb begin
      // Pull-up: plain port needs input direction, output bit set, no global disable.
      pull_d  = (PULLUP_OVERRIDE_EN & PULLUP_OVERRIDE_VAL)
              | (~PULLUP_OVERRIDE_EN & ~state_q.dir & state_q.out
                 & {`PPOM_PINS{~state_q.global_pullup_disable}});
      // Driver enable: direction bit one means output.
      oe_d    = (DIR_OVERRIDE_EN & DIR_OVERRIDE_VAL)
              | (~DIR_OVERRIDE_EN & state_q.dir);
      // Driven value: override value wins over the possibly inverted port bit.
      drive_d = (VALUE_OVERRIDE_EN & VALUE_OVERRIDE_VAL)
              | (~VALUE_OVERRIDE_EN & (state_q.out ^ TOGGLE_OVERRIDE_EN));
      // Input enable: sleep clamps the input unless a function overrides it.
      inen_d  = (INEN_OVERRIDE_EN & INEN_OVERRIDE_VAL)
              | (~INEN_OVERRIDE_EN & {`PPOM_PINS{~SLEEP}});
   end

   // ======================================================================
   // Next state
   // ======================================================================
   // The whole module state moves together; strobes and sleep are shared
   // by all eight pins of the port.
   always_comb begin
      state_d = state_q;
      // Registered pad controls keep every output straight from a flip-flop,
      // at the cost of one clock of latency from override to pad.
      state_d.pull_en = pull_d;
      state_d.pad_oe  = oe_d;
      state_d.pad_out = drive_d;
      state_d.inen    = inen_d;
      // The input buffer output, clamped low when disabled, goes out raw;
      // a consumer that is not a clock must synchronize it itself.
      state_d.raw     = PAD_IN & inen_d;
      state_d.ana     = PAD_ANALOG;
      // Two-stage synchronizer for the input register.
      state_d.sync1   = PAD_IN & inen_d;
      state_d.sync2   = state_q.sync1;
      // APB: one wait state, pready raised in the second access cycle.
      state_d.pready  = PSEL & PENABLE & ~state_q.pready;
      state_d.pslverr = PSEL & PENABLE & ~state_q.pready & ~hit_any;
      state_d.prdata  = `PPOM_RST_WORD;
      if (PSEL & PENABLE & ~state_q.pready & ~PWRITE) begin
         if (reg_hit(PADDR, `PPOM_OFF_DIR)) begin
            state_d.prdata[`PPOM_PINS-1:0] = state_q.dir;
         end else if (reg_hit(PADDR, `PPOM_OFF_OUT)) begin
            state_d.prdata[`PPOM_PINS-1:0] = state_q.out;
         end else if (reg_hit(PADDR, `PPOM_OFF_IN)) begin
            state_d.prdata[`PPOM_PINS-1:0] = state_q.sync2;
         end else if (reg_hit(PADDR, `PPOM_OFF_CTRL)) begin
            state_d.prdata[`PPOM_CTRL_PUD] = state_q.global_pullup_disable;
         end else begin
            state_d.prdata = `PPOM_RST_WORD;
         end
      end
      // Writes land only at the edge where pready is seen high.
      if (access & PWRITE) begin
         if (reg_hit(PADDR, `PPOM_OFF_DIR)) begin
            state_d.dir = PWDATA[`PPOM_PINS-1:0];
         end else if (reg_hit(PADDR, `PPOM_OFF_OUT)) begin
            state_d.out = PWDATA[`PPOM_PINS-1:0];
         end else if (reg_hit(PADDR, `PPOM_OFF_IN)) begin
            // A one toggles the output bit whatever the direction holds.
            state_d.out = state_q.out ^ PWDATA[`PPOM_PINS-1:0];
         end else if (reg_hit(PADDR, `PPOM_OFF_CTRL)) begin
            state_d.global_pullup_disable = PWDATA[`PPOM_CTRL_PUD];
         end else begin
            state_d.global_pullup_disable = state_q.global_pullup_disable;
         end
      end
   end

   // ======================================================================
   // State register
   // ======================================================================
   // Reset tri-states the pins and drops every override effect.
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         state_q.dir     <= `PPOM_RST_PINS;
         state_q.out     <= `PPOM_RST_PINS;
         state_q.global_pullup_disable     <= `PPOM_RST_BIT;
         state_q.sync1   <= `PPOM_RST_PINS;
         state_q.sync2   <= `PPOM_RST_PINS;
         state_q.pad_out <= `PPOM_RST_PINS;
         state_q.pad_oe  <= `PPOM_RST_PINS;
         state_q.pull_en <= `PPOM_RST_PINS;
         state_q.inen    <= `PPOM_RST_PINS;
         state_q.raw     <= `PPOM_RST_PINS;
         state_q.ana     <= `PPOM_RST_PINS;
         state_q.prdata  <= `PPOM_RST_WORD;
         state_q.pready  <= `PPOM_RST_BIT;
         state_q.pslverr <= `PPOM_RST_BIT;
      end else begin
         state_q <= state_d;
      end
   end

   // ======================================================================
   // Outputs
   // ======================================================================
   assign PRDATA            = state_q.prdata;
   assign PREADY            = state_q.pready;
   assign PSLVERR           = state_q.pslverr;
   assign RAW_PIN_INPUT     = state_q.raw;
   assign ANALOG_PAD_SIGNAL = state_q.ana;
   assign PAD_OUT           = state_q.pad_out;
   assign PAD_OE            = state_q.pad_oe;
   assign PULLUP_EN         = state_q.pull_en;
   assign INPUT_EN          = state_q.inen;

   // ======================================================================
   // Assertions
   // ======================================================================
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RESET);

   sequence wr_in_s;
      access && PWRITE && reg_hit(PADDR, `PPOM_OFF_IN) && PWDATA[0];
   endsequence

   sequence setup_s;
      PSEL && !PENABLE;
   endsequence

   pu_ovr_on_a: assert property (
      PULLUP_OVERRIDE_EN[1] && PULLUP_OVERRIDE_VAL[1] |=> PULLUP_EN[1])
      else $error("Pull-up override value high did not enable pull-up.");

   pu_ovr_off_a: assert property (
      PULLUP_OVERRIDE_EN[0] && !PULLUP_OVERRIDE_VAL[0] |=> !PULLUP_EN[0])
      else $error("Pull-up override value low did not disable pull-up.");

   pu_plain_a: assert property (
      !PULLUP_OVERRIDE_EN[2] |=>
      PULLUP_EN[2] == (!$past(state_q.dir[2]) && $past(state_q.out[2])
                       && !$past(state_q.global_pullup_disable)))
      else $error("Plain pull-up does not match direction, output and disable.");

   dir_ovr_a: assert property (
      DIR_OVERRIDE_EN[7] |=> PAD_OE[7] == $past(DIR_OVERRIDE_VAL[7]))
      else $error("Driver enable does not follow direction override.");

   dir_plain_a: assert property (
      !DIR_OVERRIDE_EN[4] |=> PAD_OE[4] == $past(state_q.dir[4]))
      else $error("Driver enable does not follow direction bit.");

   val_ovr_a: assert property (
      VALUE_OVERRIDE_EN[2] |=> PAD_OUT[2] == $past(VALUE_OVERRIDE_VAL[2]))
      else $error("Pin value does not follow value override.");

   val_tog_a: assert property (
      !VALUE_OVERRIDE_EN[6] |=>
      PAD_OUT[6] == ($past(state_q.out[6]) ^ $past(TOGGLE_OVERRIDE_EN[6])))
      else $error("Pin value does not follow output bit and toggle.");

   inen_ovr_a: assert property (
      INEN_OVERRIDE_EN[7] && INEN_OVERRIDE_VAL[7] && SLEEP |=> INPUT_EN[7])
      else $error("Input enable override lost against sleep.");

   sleep_clamp_a: assert property (
      !INEN_OVERRIDE_EN[0] && SLEEP && PAD_IN[0] |=> !INPUT_EN[0] && !RAW_PIN_INPUT[0])
      else $error("Sleep did not clamp the input.");

   raw_in_a: assert property (
      INEN_OVERRIDE_EN[1] && INEN_OVERRIDE_VAL[1] && PAD_IN[1] |=> RAW_PIN_INPUT[1])
      else $error("Raw input did not follow pad input.");

   toggle_wr_a: assert property (
      wr_in_s |=> state_q.out[0] != $past(state_q.out[0]))
      else $error("Write of one to input register did not toggle output bit.");

   apb_wait_a: assert property (
      setup_s ##1 (PSEL && PENABLE) |-> !PREADY ##1 PREADY)
      else $error("APB answer not given after exactly one wait state.");

endmodule

/* File: test/ppom_partner.sv */
// Behavioural model of the alternate-function modules that drive the pin overrides.
`timescale 1ns/1ps

// ==========================================================================
// Alternate-function side
// ==========================================================================
module ppom_partner (
   // Clock and reset.
   input  wire logic                clk,
   input  wire logic                reset,
   // Override pattern handed over by the bench.
   input  wire logic                load,
   input  wire logic [71:0]         ovr_word,
   // Raw pin input and the model's own synchronized copy.
   input  wire ppom_pkg::ppom_pins_t raw_in,
   output ppom_pkg::ppom_pins_t     raw_sync,
   // Overrides towards the pins.
   output ppom_pkg::ppom_pins_t     pu_en,
   output ppom_pkg::ppom_pins_t     pu_val,
   output ppom_pkg::ppom_pins_t     dir_en,
   output ppom_pkg::ppom_pins_t     dir_val,
   output ppom_pkg::ppom_pins_t     val_en,
   output ppom_pkg::ppom_pins_t     val_val,
   output ppom_pkg::ppom_pins_t     tog_en,
   output ppom_pkg::ppom_pins_t     inen_en,
   output ppom_pkg::ppom_pins_t     inen_val
);
   import ppom_pkg::*;

   logic [71:0] ovr_q;
   ppom_pins_t  s1_q;
   ppom_pins_t  s2_q;

   // Overrides come from a register, so they change only after a clock edge.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ovr_q <= 72'h0;
      end else if (load) begin
         ovr_q <= ovr_word;
      end
   end

   // The raw input is unsynchronized, so the model uses two flops of its own.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         s1_q <= 8'h00;
         s2_q <= 8'h00;
      end else begin
         s1_q <= raw_in;
         s2_q <= s1_q;
      end
   end

   // Unpack the pattern, first byte is the pull-up enable.
   assign {pu_en, pu_val, dir_en, dir_val, val_en, val_val, tog_en, inen_en, inen_val} = ovr_q;
   assign raw_sync = s2_q;
endmodule

/* File: test/ppom_top_test.sv */
// Self-checking testbench for the port pin override mux.
`timescale 1ns/1ps
`include "ppom_consts.svh"

module ppom_top_test;
   import ppom_pkg::*;

   // ======================================================================
   // Stimulus and wiring
   // ======================================================================
   logic CLK = 1'b0, RESET = 1'b1, SLEEP = 1'b0, load = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, PRDATA, rd;
   logic PREADY, PSLVERR, err;
   logic [71:0] ovr_word = 72'h0;
   ppom_pins_t ext_pins = 8'h00, ana = 8'h00, pad_in, raw, raw_sync, pe, pv, de, dv, ve, vv, te,
      ie, iv, a_out, p_out, p_oe, p_pu, p_ie;
   int num_errors = 0, tests_run = 0, cycles = 0;

   // The pad wire: driver first, then pull-up, then the outside world.
   assign pad_in = (p_oe & p_out) | (~p_oe & p_pu) | (~p_oe & ~p_pu & ext_pins);

   ppom_top ppom_top_i (.CLK(CLK), .RESET(RESET), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(PRDATA), .PREADY(PREADY),
      .PSLVERR(PSLVERR), .SLEEP(SLEEP), .PULLUP_OVERRIDE_EN(pe), .PULLUP_OVERRIDE_VAL(pv),
      .DIR_OVERRIDE_EN(de), .DIR_OVERRIDE_VAL(dv), .VALUE_OVERRIDE_EN(ve),
      .VALUE_OVERRIDE_VAL(vv), .TOGGLE_OVERRIDE_EN(te), .INEN_OVERRIDE_EN(ie),
      .INEN_OVERRIDE_VAL(iv), .RAW_PIN_INPUT(raw), .ANALOG_PAD_SIGNAL(a_out), .PAD_IN(pad_in),
      .PAD_ANALOG(ana), .PAD_OUT(p_out), .PAD_OE(p_oe), .PULLUP_EN(p_pu), .INPUT_EN(p_ie));

   ppom_partner ppom_partner_i (.clk(CLK), .reset(RESET), .load(load), .ovr_word(ovr_word),
      .raw_in(raw), .raw_sync(raw_sync), .pu_en(pe), .pu_val(pv), .dir_en(de), .dir_val(dv),
      .val_en(ve), .val_val(vv), .tog_en(te), .inen_en(ie), .inen_val(iv));

   // Free-running clock, 20 ns period.
   initial begin
      forever #10 CLK = ~CLK;
   end

   // ======================================================================
   // Shared tasks
   // ======================================================================
   task automatic wrap_up;
      if (num_errors == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One APB transfer; the request is held until PREADY is seen at an edge.
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge CLK);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge CLK);
      penable <= 1'b1;
      do begin
         @(posedge CLK);
         n++;
      end while (PREADY !== 1'b1 && n < 50);
      rd = PRDATA;
      err = PSLVERR;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) chk(32'h1, 32'h0);
   endtask

   // Hand a new override pattern to the partner and let the pads settle.
   task automatic ovr(input logic [71:0] w);
      @(posedge CLK);
      ovr_word <= w;
      load <= 1'b1;
      @(posedge CLK);
      load <= 1'b0;
      repeat (4) @(posedge CLK);
   endtask

   // Plain port set-up through the register bus.
   task automatic port(input logic [7:0] dir, input logic [7:0] out, input logic global_pullup_disable);
      apb(1'b1, `PPOM_OFF_DIR, {24'h0, dir});
      apb(1'b1, `PPOM_OFF_OUT, {24'h0, out});
      apb(1'b1, `PPOM_OFF_CTRL, {31'h0, global_pullup_disable});
      repeat (4) @(posedge CLK);
   endtask

   // ======================================================================
   // Scenarios
   // ======================================================================
   task automatic t_reset;
      chk({p_oe, p_pu, p_ie, p_out}, 32'h0);
      apb(1'b0, `PPOM_OFF_DIR, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, `PPOM_OFF_CTRL, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 12'h040, 32'h0);
      chk({31'h0, err}, 32'h1);
   endtask

   task automatic t_plain;
      for (int global_pullup_disable = 0; global_pullup_disable < 2; global_pullup_disable++) begin
         port(8'h0C, 8'h0A, global_pullup_disable[0]);
         chk({24'h0, p_pu}, global_pullup_disable ? 32'h0 : 32'h02);
         chk({p_oe, p_out}, 32'h0C0A);
      end
   endtask

   task automatic t_override;
      port(8'h0F, 8'hFF, 1'b1);
      ovr({8'hFF, 8'h5A, 8'hF0, 8'hCC, 8'h0F, 8'h05, 8'h30, 8'h00, 8'h00});
      chk({24'h0, p_pu}, 32'h5A);
      chk({24'h0, p_oe}, 32'hCF);
      chk({24'h0, p_out}, 32'hC5);
      ovr(72'h0);
   endtask

   task automatic t_input;
      port(8'h00, 8'h0A, 1'b1);
      ext_pins <= 8'hA7;
      ana <= 8'h3C;
      SLEEP <= 1'b1;
      ovr({56'h0, 8'h8F, 8'h83});
      chk({p_ie, raw}, 32'h8383);
      SLEEP <= 1'b0;
      repeat (4) @(posedge CLK);
      chk({p_ie, raw, raw_sync}, 32'hF3A3A3);
      ovr(72'h0);
      apb(1'b0, `PPOM_OFF_IN, 32'h0);
      chk(rd, 32'hA7);
      chk({24'h0, a_out}, 32'h3C);
   endtask

   task automatic t_toggle;
      apb(1'b1, `PPOM_OFF_IN, 32'h81);
      apb(1'b0, `PPOM_OFF_OUT, 32'h0);
      chk(rd, 32'h8B);
   endtask

   // Hang guard: the scenarios need well under two thousand cycles.
   always @(posedge CLK) begin
      cycles++;
      if (cycles == 5000) begin
         num_errors++;
         wrap_up();
      end
   end

   // Main sequence.
   initial begin
      repeat (20) @(posedge CLK);
      RESET <= 1'b0;
      t_reset();
      t_plain();
      t_override();
      t_input();
      t_toggle();
      wrap_up();
   end
endmodule
